// ---- hdl/iso_rx_ctx_pkg.sv ----
//Behaviour
//- Software sets run (bit 15) to start and clears it to stop descriptor processing; hardware changes it only at reset.
//- Control bits 14:13 and 9:8 always read as zero.
//- Software sets wake (bit 12) to continue or resume processing; the device clears it on every descriptor fetch except one issued in the cycle software sets it.
//- The device sets dead (bit 11) on a fatal error and clears it when software clears run.
//- The device holds active (bit 10) high while the context processes descriptors.
//- Bits 7:5 report the receive speed: 000 is 100, 001 is 200, 010 is 400 Mbit/s, others reserved.
//- After an input descriptor command completes, its event code is written into bits 4:0.
//- When run is set the first descriptor block is fetched from command-pointer bits 31:4.
//- The descriptor count in command-pointer bits 3:0 is 0 or 1 in buffer-fill mode and 0 to 8 otherwise.
//- Eight contexts exist, each command pointer at 40Ch plus 32 bytes per context.
//- A packet is accepted when its tag has its enable set: bit 31 tag 11b, 30 tag 10b, 29 tag 01b, 28 tag 00b.
//- The control register has a set address and a clear address four bytes above; ones written set or clear bits, but a write to the clear address leaves wake set.
//- With start-on-cycle enable (bit 29) set the context starts on the matching cycle, and the enable clears once active.
//- Outside multichannel mode only packets whose channel equals match bits 5:0 are accepted.
package iso_rx_ctx_pkg;
	localparam int NUM_CTX = 8;
	localparam int CTX_W = 3;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int INT_W = 16;
	localparam logic [15:0] CTRL_SET_BASE = 16'h0400;
	localparam logic [15:0] CTRL_CLR_BASE = 16'h0404;
	localparam logic [15:0] CMD_PTR_BASE = 16'h040c;
	localparam logic [15:0] MATCH_BASE = 16'h410c;
	localparam logic [15:0] CTX_STRIDE = 16'h0020;
	localparam logic [15:0] INT_STATUS_ADDR = 16'h0500;
	localparam logic [15:0] INT_MASK_ADDR = 16'h0504;
	// Control register fields
	localparam int RUN_BIT = 15;
	localparam int WAKE_BIT = 12;
	localparam int DEAD_BIT = 11;
	localparam int ACTIVE_BIT = 10;
	localparam int MODE_LSB = 27;
	localparam int MODE_MSB = 31;
	localparam int MODE_W = 5;
	localparam int MODE_BUF_FILL = 4;
	localparam int MODE_CYC_EN = 2;
	localparam int MODE_MULTI = 1;
	localparam int SPD_LSB = 5;
	localparam int SPD_MSB = 7;
	localparam int EVT_LSB = 0;
	localparam int EVT_MSB = 4;
	// Command pointer and match fields
	localparam int PTR_LSB = 4;
	localparam int Z_MSB = 3;
	localparam logic [3:0] Z_MAX_FILL = 4'h1;
	localparam logic [3:0] Z_MAX_PPB = 4'h8;
	localparam logic [3:0] Z_END = 4'h0;
	localparam int TAG_LSB = 28;
	localparam int CYC_LSB = 12;
	localparam int CYC_MSB = 26;
	localparam int CHAN_MSB = 5;
	localparam logic [31:0] MATCH_WMASK = 32'hf7ff_ff7f;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [2:0] SPD_100 = 3'h0;
	localparam logic [2:0] SPD_200 = 3'h1;
	localparam logic [2:0] SPD_400 = 3'h2;

	typedef struct packed {
		logic [1:0] tag;
		logic [5:0] channel;
	} pkt_s;

	typedef struct packed {
		logic [2:0] ctx;
		logic [31:0] addr;
	} fetch_s;

	typedef struct packed {
		logic err;
		logic [31:0] nextPtr;
	} fresp_s;

	typedef struct packed {
		logic [2:0] ctx;
		logic [4:0] evt;
		logic [2:0] spd;
	} cmpl_s;

	typedef enum logic {
		FS_IDLE = 1'b0,
		FS_WAIT = 1'b1
	} fetch_state_e;
endpackage

// ---- hdl/iso_rx_ctx_ctrl.sv ----
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module iso_rx_ctx_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [15:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Link packets and cycle time
	input wire logic pktValid,
	input wire iso_rx_ctx_pkg::pkt_s pkt,
	input wire logic [14:0] cycleTime,
	output logic [7:0] pktAccept,
	// Descriptor completion
	input wire logic cmplValid,
	input wire iso_rx_ctx_pkg::cmpl_s cmpl,
	// Descriptor fetch
	output logic fetchReq,
	output iso_rx_ctx_pkg::fetch_s fetchCmd,
	input wire logic fetchDone,
	input wire iso_rx_ctx_pkg::fresp_s fetchResp,
	// Interrupt
	output logic irq
);
	localparam int N = iso_rx_ctx_pkg::NUM_CTX;

	function automatic logic [15:0] ctxAddr(input logic [15:0] base,
		input int unsigned n);
		return base + 16'(n) * iso_rx_ctx_pkg::CTX_STRIDE;
	endfunction

	logic rstMeta_r, rstSyncN_r;
	logic [N-1:0] setHit, clrHit, ptrHit, matchHit;
	logic [N-1:0] run_r, wake_r, dead_r, active_r, pending_r;
	logic [N-1:0] eligible, badZ, fatal, issue, fetchOk, endList, cmplHit;
	logic [iso_rx_ctx_pkg::MODE_W-1:0] mode_r [N];
	logic [31:0] cmdPtr_r [N];
	logic [31:0] match_r [N];
	logic [2:0] spd_r [N];
	logic [4:0] evt_r [N];
	logic [N-1:0] pktAccept_r;
	logic [31:0] rdData_r, rdData_nxt;
	logic [iso_rx_ctx_pkg::INT_W-1:0] intStatus_r, intStatus_nxt, intMask_r;
	logic irq_r;
	logic fetchReq_r;
	iso_rx_ctx_pkg::fetch_s fetchCmd_r;
	iso_rx_ctx_pkg::fetch_state_e state_r;
	logic anyIssue;
	logic [2:0] selCtx;

	assign regRdData = rdData_r;
	assign pktAccept = pktAccept_r;
	assign fetchReq = fetchReq_r;
	assign fetchCmd = fetchCmd_r;
	assign irq = irq_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSyncN_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSyncN_r <= rstMeta_r;
		end
	end

	// Address decode and per-context events
	always_comb begin
		for (int n = 0; n < N; n++) begin
			setHit[n] = regWr &&
				regAddr == ctxAddr(iso_rx_ctx_pkg::CTRL_SET_BASE, n);
			clrHit[n] = regWr &&
				regAddr == ctxAddr(iso_rx_ctx_pkg::CTRL_CLR_BASE, n);
			ptrHit[n] = regAddr == ctxAddr(iso_rx_ctx_pkg::CMD_PTR_BASE, n);
			matchHit[n] = regAddr == ctxAddr(iso_rx_ctx_pkg::MATCH_BASE, n);
			badZ[n] = mode_r[n][iso_rx_ctx_pkg::MODE_BUF_FILL] ?
				cmdPtr_r[n][iso_rx_ctx_pkg::Z_MSB:0] > iso_rx_ctx_pkg::Z_MAX_FILL :
				cmdPtr_r[n][iso_rx_ctx_pkg::Z_MSB:0] > iso_rx_ctx_pkg::Z_MAX_PPB;
			eligible[n] = run_r[n] && pending_r[n] && !dead_r[n] &&
				cmdPtr_r[n][iso_rx_ctx_pkg::Z_MSB:0] != iso_rx_ctx_pkg::Z_END &&
				(!mode_r[n][iso_rx_ctx_pkg::MODE_CYC_EN] ||
				cycleTime == match_r[n][iso_rx_ctx_pkg::CYC_MSB:
				iso_rx_ctx_pkg::CYC_LSB]);
			cmplHit[n] = cmplValid && cmpl.ctx == 3'(n);
			fetchOk[n] = state_r == iso_rx_ctx_pkg::FS_WAIT && fetchDone &&
				fetchCmd_r.ctx == 3'(n) && !fetchResp.err;
			endList[n] = cmplHit[n] &&
				cmdPtr_r[n][iso_rx_ctx_pkg::Z_MSB:0] == iso_rx_ctx_pkg::Z_END;
		end
	end

	// Lowest eligible context wins the fetch port
	always_comb begin
		anyIssue = 1'b0;
		selCtx = 3'h0;
		issue = '0;
		fatal = '0;
		for (int n = N - 1; n >= 0; n--) begin
			if (eligible[n] && !badZ[n] && state_r == iso_rx_ctx_pkg::FS_IDLE) begin
				anyIssue = 1'b1;
				selCtx = 3'(n);
			end
		end
		for (int n = 0; n < N; n++) begin
			issue[n] = anyIssue && selCtx == 3'(n);
			fatal[n] = (eligible[n] && badZ[n]) ||
				(state_r == iso_rx_ctx_pkg::FS_WAIT && fetchDone &&
				fetchCmd_r.ctx == 3'(n) && fetchResp.err);
		end
	end

	// Run changes only by software
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			run_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (setHit[n] && regWrData[iso_rx_ctx_pkg::RUN_BIT]) begin
					run_r[n] <= 1'b1;
				end else if (clrHit[n] && regWrData[iso_rx_ctx_pkg::RUN_BIT]) begin
					run_r[n] <= 1'b0;
				end
			end
		end
	end

	// Mode bits; start-on-cycle enable clears when the context goes active
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			for (int n = 0; n < N; n++) begin
				mode_r[n] <= '0;
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (setHit[n]) begin
					mode_r[n] <= mode_r[n] | regWrData[iso_rx_ctx_pkg::MODE_MSB:
						iso_rx_ctx_pkg::MODE_LSB];
				end else if (clrHit[n]) begin
					mode_r[n] <= mode_r[n] & ~regWrData[iso_rx_ctx_pkg::MODE_MSB:
						iso_rx_ctx_pkg::MODE_LSB];
				end else if (fetchOk[n] && !active_r[n]) begin
					mode_r[n][iso_rx_ctx_pkg::MODE_CYC_EN] <= 1'b0;
				end
			end
		end
	end

	// Wake: software set wins over the fetch clear
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			wake_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (setHit[n] && regWrData[iso_rx_ctx_pkg::WAKE_BIT]) begin
					wake_r[n] <= 1'b1;
				end else if (issue[n]) begin
					wake_r[n] <= 1'b0;
				end
			end
		end
	end

	// Dead: fatal error wins over the run clear
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			dead_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (fatal[n]) begin
					dead_r[n] <= 1'b1;
				end else if (clrHit[n] && regWrData[iso_rx_ctx_pkg::RUN_BIT]) begin
					dead_r[n] <= 1'b0;
				end
			end
		end
	end

	// Active from first successful fetch to end of list, stop or error
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			active_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if ((clrHit[n] && regWrData[iso_rx_ctx_pkg::RUN_BIT]) || fatal[n] ||
					endList[n]) begin
					active_r[n] <= 1'b0;
				end else if (fetchOk[n]) begin
					active_r[n] <= 1'b1;
				end
			end
		end
	end

	// Fetch pending: start, wake, or completion with more descriptors
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			pending_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (setHit[n] && ((regWrData[iso_rx_ctx_pkg::RUN_BIT] && !run_r[n]) ||
					regWrData[iso_rx_ctx_pkg::WAKE_BIT])) begin
					pending_r[n] <= 1'b1;
				end else if (cmplHit[n] && !endList[n]) begin
					pending_r[n] <= 1'b1;
				end else if (issue[n] || !run_r[n] || fatal[n]) begin
					pending_r[n] <= 1'b0;
				end
			end
		end
	end

	// Command pointer: software write, or next pointer after a fetch
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			for (int n = 0; n < N; n++) begin
				cmdPtr_r[n] <= iso_rx_ctx_pkg::RESET_WORD;
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (regWr && ptrHit[n]) begin
					cmdPtr_r[n] <= regWrData;
				end else if (fetchOk[n]) begin
					cmdPtr_r[n] <= fetchResp.nextPtr;
				end
			end
		end
	end

	// Packet match register
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			for (int n = 0; n < N; n++) begin
				match_r[n] <= iso_rx_ctx_pkg::RESET_WORD;
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (regWr && matchHit[n]) begin
					match_r[n] <= regWrData & iso_rx_ctx_pkg::MATCH_WMASK;
				end
			end
		end
	end

	// Speed and event code come only from completions
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			for (int n = 0; n < N; n++) begin
				spd_r[n] <= iso_rx_ctx_pkg::SPD_100;
				evt_r[n] <= '0;
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (cmplHit[n]) begin
					spd_r[n] <= cmpl.spd;
					evt_r[n] <= cmpl.evt;
				end
			end
		end
	end

	// Descriptor fetch port
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			state_r <= iso_rx_ctx_pkg::FS_IDLE;
			fetchReq_r <= 1'b0;
			fetchCmd_r <= '0;
		end else begin
			unique case (state_r)
				iso_rx_ctx_pkg::FS_IDLE: begin
					if (anyIssue) begin
						state_r <= iso_rx_ctx_pkg::FS_WAIT;
						fetchReq_r <= 1'b1;
						fetchCmd_r.ctx <= selCtx;
						fetchCmd_r.addr <= {cmdPtr_r[selCtx][31:iso_rx_ctx_pkg::PTR_LSB],
							4'h0};
					end
				end
				iso_rx_ctx_pkg::FS_WAIT: begin
					fetchReq_r <= 1'b0;
					if (fetchDone) begin
						state_r <= iso_rx_ctx_pkg::FS_IDLE;
					end
				end
			endcase
		end
	end

	// Packet filter
	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			pktAccept_r <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				pktAccept_r[n] <= pktValid && active_r[n] &&
					match_r[n][iso_rx_ctx_pkg::TAG_LSB + int'(pkt.tag)] &&
					(mode_r[n][iso_rx_ctx_pkg::MODE_MULTI] ||
					pkt.channel == match_r[n][iso_rx_ctx_pkg::CHAN_MSB:0]);
			end
		end
	end

	// Interrupts: completions in low byte, fatal errors in high byte
	always_comb begin
		intStatus_nxt = intStatus_r;
		if (regWr && regAddr == iso_rx_ctx_pkg::INT_STATUS_ADDR) begin
			intStatus_nxt = intStatus_nxt & ~regWrData[iso_rx_ctx_pkg::INT_W-1:0];
		end
		intStatus_nxt = intStatus_nxt | {fatal & ~dead_r, cmplHit};
	end

	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			intStatus_r <= '0;
			intMask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			intStatus_r <= intStatus_nxt;
			if (regWr && regAddr == iso_rx_ctx_pkg::INT_MASK_ADDR) begin
				intMask_r <= regWrData[iso_rx_ctx_pkg::INT_W-1:0];
			end
			irq_r <= |(intStatus_r & intMask_r);
		end
	end

	// Read data; reserved control bits stay zero
	always_comb begin
		rdData_nxt = '0;
		for (int n = 0; n < N; n++) begin
			if (regAddr == ctxAddr(iso_rx_ctx_pkg::CTRL_SET_BASE, n) ||
				regAddr == ctxAddr(iso_rx_ctx_pkg::CTRL_CLR_BASE, n)) begin
				rdData_nxt[iso_rx_ctx_pkg::MODE_MSB:iso_rx_ctx_pkg::MODE_LSB] = mode_r[n];
				rdData_nxt[iso_rx_ctx_pkg::RUN_BIT] = run_r[n];
				rdData_nxt[iso_rx_ctx_pkg::WAKE_BIT] = wake_r[n];
				rdData_nxt[iso_rx_ctx_pkg::DEAD_BIT] = dead_r[n];
				rdData_nxt[iso_rx_ctx_pkg::ACTIVE_BIT] = active_r[n];
				rdData_nxt[iso_rx_ctx_pkg::SPD_MSB:iso_rx_ctx_pkg::SPD_LSB] = spd_r[n];
				rdData_nxt[iso_rx_ctx_pkg::EVT_MSB:iso_rx_ctx_pkg::EVT_LSB] = evt_r[n];
			end
			if (ptrHit[n]) begin
				rdData_nxt = cmdPtr_r[n];
			end
			if (matchHit[n]) begin
				rdData_nxt = match_r[n];
			end
		end
		if (regAddr == iso_rx_ctx_pkg::INT_STATUS_ADDR) begin
			rdData_nxt = {16'h0000, intStatus_r};
		end
		if (regAddr == iso_rx_ctx_pkg::INT_MASK_ADDR) begin
			rdData_nxt = {16'h0000, intMask_r};
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN_r) begin
		if (!rstSyncN_r) begin
			rdData_r <= '0;
		end else if (regRd) begin
			rdData_r <= rdData_nxt;
		end else begin
			rdData_r <= '0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSyncN_r);

	// Checks watch contexts 0, 2, 3 and 4; the scenarios also exercise contexts 1 and 5
	property p_run_sw_only;
		$changed(run_r[2]) |-> $past(setHit[2] || clrHit[2]);
	endproperty
	a_run_sw_only: assert property (p_run_sw_only)
		else $error("run changed without a software write");

	property p_reserved_zero;
		regRd && regAddr == iso_rx_ctx_pkg::CTRL_SET_BASE |=>
			rdData_r[14:13] == 2'b00 && rdData_r[9:8] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bits read non-zero");

	property p_wake_cleared;
		issue[2] && !(setHit[2] && regWrData[iso_rx_ctx_pkg::WAKE_BIT]) |=> !wake_r[2];
	endproperty
	a_wake_cleared: assert property (p_wake_cleared)
		else $error("wake not cleared by fetch");

	property p_dead_cleared;
		clrHit[3] && regWrData[iso_rx_ctx_pkg::RUN_BIT] && !fatal[3] |=> !dead_r[3];
	endproperty
	a_dead_cleared: assert property (p_dead_cleared)
		else $error("dead not cleared by run clear");

	property p_active_needs_run;
		active_r[2] |-> run_r[2] && !dead_r[2];
	endproperty
	a_active_needs_run: assert property (p_active_needs_run)
		else $error("active without run");

	property p_event_code;
		cmplHit[2] |=> evt_r[2] == $past(cmpl.evt) && spd_r[2] == $past(cmpl.spd);
	endproperty
	a_event_code: assert property (p_event_code)
		else $error("event code or speed not captured");

	property p_fetch_addr;
		issue[2] |=> fetchReq_r && fetchCmd_r.ctx == 3'h2 &&
			fetchCmd_r.addr == {$past(cmdPtr_r[2][31:4]), 4'h0} ##1 !fetchReq_r;
	endproperty
	a_fetch_addr: assert property (p_fetch_addr)
		else $error("fetch address or pulse wrong");

	property p_bad_z_fatal;
		eligible[3] && badZ[3] |=> dead_r[3] && !fetchReq_r[*1];
	endproperty
	a_bad_z_fatal: assert property (p_bad_z_fatal)
		else $error("illegal descriptor count not fatal");

	property p_accept;
		pktAccept_r[2] |-> $past(match_r[2][iso_rx_ctx_pkg::TAG_LSB + int'(pkt.tag)]) &&
			$past(active_r[2]);
	endproperty
	a_accept: assert property (p_accept)
		else $error("packet accepted with tag disabled");

	property p_cyc_en_clear;
		$rose(active_r[4]) |-> !mode_r[4][iso_rx_ctx_pkg::MODE_CYC_EN];
	endproperty
	a_cyc_en_clear: assert property (p_cyc_en_clear)
		else $error("start-on-cycle enable still set when active");

	property p_dead_hw_only;
		$rose(dead_r[3]) |-> $past(fatal[3]);
	endproperty
	a_dead_hw_only: assert property (p_dead_hw_only)
		else $error("dead set without fatal error");

	c_start: cover property (setHit[2] ##[1:20] $rose(active_r[2]));
	c_accept: cover property (pktAccept_r[2]);
	c_fatal: cover property ($rose(dead_r[3]));
	c_irq: cover property ($rose(irq_r));
endmodule
`default_nettype wire

// ---- tb/iso_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module iso_link_model (
	// Clock
	input wire logic ref_clk,
	// Bench controls
	input wire logic errNext,
	input wire logic [3:0] lat,
	// Packets, cycle time and completions
	output logic pktValid,
	output iso_rx_ctx_pkg::pkt_s pkt,
	output logic [14:0] cycleTime,
	output logic cmplValid,
	output iso_rx_ctx_pkg::cmpl_s cmpl,
	// Descriptor fetch
	input wire logic fetchReq,
	output logic fetchDone,
	output iso_rx_ctx_pkg::fresp_s fetchResp
);
	initial begin
		pktValid = 1'b0;
		pkt = '0;
		cycleTime = 15'h0000;
		cmplValid = 1'b0;
		cmpl = '0;
		fetchDone = 1'b0;
		fetchResp = '0;
	end

	// Released lines show the inverse so stale values never look valid
	task automatic send_pkt(input logic [1:0] tag, input logic [5:0] ch);
		@(posedge ref_clk);
		pktValid <= 1'b1;
		pkt <= {tag, ch};
		@(posedge ref_clk);
		pktValid <= 1'b0;
		pkt <= ~pkt;
	endtask

	task automatic send_cmpl(input logic [2:0] c, input logic [4:0] e,
			input logic [2:0] s);
		@(posedge ref_clk);
		cmplValid <= 1'b1;
		cmpl <= {c, e, s};
		@(posedge ref_clk);
		cmplValid <= 1'b0;
		cmpl <= ~cmpl;
	endtask

	task automatic set_cycle(input logic [14:0] v);
		@(posedge ref_clk);
		cycleTime <= v;
	endtask

	// Every next pointer ends the list with a zero count
	always begin
		@(posedge ref_clk);
		if (fetchReq === 1'b1) begin
			repeat (lat) @(posedge ref_clk);
			fetchDone <= 1'b1;
			fetchResp <= {errNext, 32'h0000_2000};
			@(posedge ref_clk);
			fetchDone <= 1'b0;
			fetchResp <= ~fetchResp;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb_iso_rx_ctx_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_iso_rx_ctx_ctrl;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	logic pktValid;
	iso_rx_ctx_pkg::pkt_s pkt;
	logic [14:0] cycleTime;
	logic [7:0] pktAccept;
	logic cmplValid;
	iso_rx_ctx_pkg::cmpl_s cmpl;
	logic fetchReq;
	iso_rx_ctx_pkg::fetch_s fetchCmd;
	logic fetchDone;
	iso_rx_ctx_pkg::fresp_s fetchResp;
	logic irq;
	logic errNext = 1'b0;
	logic [3:0] lat = 4'h0;
	int errCount = 0;
	int compares = 0;

	iso_rx_ctx_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .pktValid(pktValid), .pkt(pkt),
		.cycleTime(cycleTime), .pktAccept(pktAccept), .cmplValid(cmplValid),
		.cmpl(cmpl), .fetchReq(fetchReq), .fetchCmd(fetchCmd),
		.fetchDone(fetchDone), .fetchResp(fetchResp), .irq(irq));

	iso_link_model lnk (.ref_clk(ref_clk), .errNext(errNext), .lat(lat),
		.pktValid(pktValid), .pkt(pkt), .cycleTime(cycleTime),
		.cmplValid(cmplValid), .cmpl(cmpl), .fetchReq(fetchReq),
		.fetchDone(fetchDone), .fetchResp(fetchResp));

	always #5 ref_clk = ~ref_clk;

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errCount++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, errCount);
		if (errCount == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [15:0] a,
			input logic [31:0] exp);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		check(what, regRdData, exp);
	endtask

	task automatic wait_fetch(input logic [2:0] ctx, input logic [31:0] addr);
		int i;
		for (i = 0; i < 40 && fetchReq !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (fetchReq !== 1'b1) begin
			errCount++;
			$display("unexpected fetch: expected request seen none");
			finish_test();
		end else begin
			check("fetch ctx", {29'h0, fetchCmd.ctx}, {29'h0, ctx});
			check("fetch addr", fetchCmd.addr, addr);
			repeat (lat + 4) @(posedge ref_clk);
		end
	endtask

	task automatic t_reset();
		rdchk("ctrl", 16'h0400, 32'h0000_0000);
		rdchk("cmd ptr", 16'h040c, 32'h0000_0000);
		rdchk("match", 16'h410c, 32'h0000_0000);
		rdchk("unmapped", 16'h0600, 32'h0000_0000);
		check("irq", {31'h0, irq}, 32'h0);
	endtask

	task automatic t_reserved();
		wr(16'h0420, 32'hffff_ffff);
		rdchk("ctrl set", 16'h0420, 32'hf800_9000);
		rdchk("ctrl alias", 16'h0424, 32'hf800_9000);
		wr(16'h0424, 32'hffff_ffff);
		rdchk("ctrl clear", 16'h0420, 32'h0000_1000);
	endtask

	task automatic t_fetch_pkt();
		logic [31:0] s;
		wr(16'h044c, 32'h0000_1001);
		wr(16'h414c, 32'ha800_0085);
		rdchk("match rb", 16'h414c, 32'ha000_0005);
		wr(16'h0440, 32'h0000_9000);
		wait_fetch(3'h2, 32'h0000_1000);
		rdchk("ctrl active", 16'h0440, 32'h0000_8400);
		rdchk("next ptr", 16'h044c, 32'h0000_2000);
		for (int t = 0; t < 4; t++) begin
			lnk.send_pkt(t[1:0], 6'h05);
			#1;
			check("accept", {24'h0, pktAccept},
				(t == 1 || t == 3) ? 32'h0000_0004 : 32'h0);
		end
		lnk.send_pkt(2'h3, 6'h06);
		#1;
		check("channel", {24'h0, pktAccept}, 32'h0);
		for (s = 0; s < 3; s++) begin
			lnk.send_cmpl(3'h2, 5'h10 + s[4:0], s[2:0]);
			repeat (2) @(posedge ref_clk);
			rdchk("evt spd", 16'h0440, 32'h0000_8010 + (s << 5) + s);
		end
		check("irq masked", {31'h0, irq}, 32'h0);
		rdchk("status", 16'h0500, 32'h0000_0004);
		wr(16'h0504, 32'h0000_0004);
		repeat (2) @(posedge ref_clk);
		#1;
		check("irq on", {31'h0, irq}, 32'h1);
		wr(16'h0500, 32'h0000_0004);
		repeat (2) @(posedge ref_clk);
		#1;
		check("irq off", {31'h0, irq}, 32'h0);
		rdchk("status clr", 16'h0500, 32'h0000_0000);
		wr(16'h0444, 32'h0000_8000);
		rdchk("run off", 16'h0440, 32'h0000_0052);
	endtask

	task automatic t_dead();
		int n;
		n = 0;
		wr(16'h046c, 32'h0000_3002);
		wr(16'h0460, 32'h8000_8000);
		repeat (5) begin
			@(posedge ref_clk);
			#1;
			n += (fetchReq === 1'b1) ? 1 : 0;
		end
		check("no fetch", n, 32'h0);
		rdchk("dead", 16'h0460, 32'h8000_8800);
		rdchk("fatal st", 16'h0500, 32'h0000_0800);
		wr(16'h0500, 32'h0000_0800);
		wr(16'h0464, 32'h8000_8000);
		rdchk("dead clr", 16'h0460, 32'h0000_0000);
	endtask

	task automatic t_fetch_err();
		lat <= 4'h3;
		errNext <= 1'b1;
		wr(16'h04ac, 32'h0000_5008);
		wr(16'h04a0, 32'h0000_8000);
		wait_fetch(3'h5, 32'h0000_5000);
		rdchk("err dead", 16'h04a0, 32'h0000_8800);
		errNext <= 1'b0;
		lat <= 4'h0;
		wr(16'h04a4, 32'h0000_8000);
		rdchk("err clr", 16'h04a0, 32'h0000_0000);
	endtask

	task automatic t_cycle();
		int n;
		n = 0;
		wr(16'h048c, 32'h0000_4001);
		wr(16'h418c, 32'h0012_3000);
		wr(16'h0480, 32'h2000_8000);
		repeat (10) begin
			@(posedge ref_clk);
			#1;
			n += (fetchReq === 1'b1) ? 1 : 0;
		end
		check("cycle wait", n, 32'h0);
		lnk.set_cycle(15'h0123);
		wait_fetch(3'h4, 32'h0000_4000);
		rdchk("cyc clr", 16'h0480, 32'h0000_8400);
		wr(16'h0484, 32'h0000_8000);
		rdchk("stop", 16'h0480, 32'h0000_0000);
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_reserved();
		t_fetch_pkt();
		t_dead();
		t_fetch_err();
		t_cycle();
		finish_test();
	end
endmodule
`default_nettype wire
